// File: shared/lsm_pkg.sv
// Constants, types and register map of the bus system basis chip mode controller.
// Assumes a 125 MHz system clock; all times are converted to cycles here.
package lsm_pkg;

   localparam int CLK_MHZ        = 125;
   localparam int CNT_W          = 20;

   // Internal reset hold after power-up or supply fault
   localparam int RESET_HOLD_MS  = 4;
   localparam int RESET_HOLD_CYC = RESET_HOLD_MS * 1000 * CLK_MHZ;

   // Bus dominant and local wake low time
   localparam int WAKE_TIME_US   = 100;
   localparam int WAKE_CYC       = WAKE_TIME_US * CLK_MHZ;

   // Enable may fall this much before transmit data when Sleep is requested
   localparam int MODE_SEL_NS    = 3200;
   localparam int MODE_SEL_CYC   = MODE_SEL_NS * CLK_MHZ / 1000;

   // Transmit-data dominant time-out, no figure given, plain default
   localparam int DOM_TIMEOUT_CYC = 100000;

   // Register map, byte addresses on the Avalon-MM slave
   localparam logic [3:0]  CTRL_ADDR      = 4'h0;
   localparam logic [3:0]  STATUS_ADDR    = 4'h4;
   localparam int          CTRL_BUS_WAKE  = 0;
   localparam int          CTRL_LOC_WAKE  = 1;
   localparam logic [1:0]  CTRL_RESET     = 2'h3;
   localparam int          STAT_MODE_LSB  = 0;
   localparam int          STAT_FLAG_LSB  = 4;
   localparam int          STAT_RESET_N   = 7;
   localparam int          STAT_DOM_TO    = 8;

   typedef enum logic [1:0] {
      MODE_FAILSAFE,
      MODE_NORMAL,
      MODE_SILENT,
      MODE_SLEEP
   } lsm_mode_t;

   typedef struct packed {
      logic en;
      logic txd;
      logic bus_rx;
      logic bus_prewake;
      logic local_wake;
      logic vs_uv;
      logic vcc_uv;
   } lsm_pins_t;

   localparam lsm_pins_t PINS_RESET = '{en: 1'b0, txd: 1'b1, bus_rx: 1'b1, bus_prewake: 1'b0,
                                        local_wake: 1'b1, vs_uv: 1'b0, vcc_uv: 1'b0};

   typedef struct packed {
      logic vs_uv;
      logic local_wake;
      logic bus_wake;
   } lsm_flags_t;

endpackage

// File: testbench/lsm_host_model.sv
// Host microcontroller model: drives enable and transmit data, shares the TXD pin.
// Assumes the TXD pin has a pull-up and resolves as a wired-AND of both drivers.
`timescale 1ns/1ps
module lsm_host_model
   import lsm_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic [1:0] cmd_i,
   input  wire logic       tx_data_i,
   input  wire logic       dev_txd_i,
   input  wire logic       dev_txd_oe_n_i,
   output logic            en_o,
   output logic            txd_pin_o
);
   localparam logic [1:0] HC_RUN    = 2'h0;
   localparam logic [1:0] HC_SLEEP  = 2'h1;
   localparam logic [1:0] HC_SILENT = 2'h2;
   localparam logic [1:0] HC_FREE   = 2'h3;
   logic en_q       = 1'b0;
   logic host_drive = 1'b0;
   logic host_txd   = 1'b1;
   // Enable and transmit data change on one edge, the safest way into Sleep
   always @(posedge sys_clk_i) begin
      en_q       <= (cmd_i == HC_RUN);
      host_drive <= (cmd_i != HC_FREE);
      host_txd   <= (cmd_i == HC_RUN) ? tx_data_i : (cmd_i == HC_SILENT);
   end
   assign en_o      = en_q;
   // Released pin reads the device's code, or the pull-up
   assign txd_pin_o = (dev_txd_oe_n_i | dev_txd_i) & (~host_drive | host_txd);
endmodule // lsm_host_model

// File: testbench/lsm_mode_ctrl_tb_top.sv
// Self-checking bench for the mode controller: host model on the pins, Avalon-MM tasks.
// Assumes shortened hold, wake and time-out counts; the 400-cycle select window is kept.
`timescale 1ns/1ps
module lsm_mode_ctrl_tb_top
   import lsm_pkg::*;
;
   localparam logic [1:0] HC_RUN    = 2'h0;
   localparam logic [1:0] HC_SLEEP  = 2'h1;
   localparam logic [1:0] HC_SILENT = 2'h2;
   localparam logic [1:0] HC_FREE   = 2'h3;
   logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic        en, txd_pin, txd_o, txd_oe_n, rxd, bus_rx, bus_prewake, local_wake, vs_uv, vcc_uv;
   logic        bus_tx_dom, xcvr_en, term_en, rcv_en, reg_en, int_rst_n, tx_data;
   logic [1:0]  host_cmd;
   lsm_mode_t   mode;
   int          fail_count = 0;
   int          total_checks = 0;

   lsm_mode_ctrl #(.RESET_HOLD(50), .WAKE_TIME(20), .DOM_TIMEOUT(30)) DUT (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .avs_address_i(avs_address), .avs_read_i(avs_read),
      .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
      .avs_waitrequest_o(avs_waitrequest), .en_i(en), .txd_i(txd_pin), .txd_o(txd_o),
      .txd_oe_n_o(txd_oe_n), .rxd_o(rxd), .bus_rx_i(bus_rx), .bus_prewake_i(bus_prewake),
      .local_wake_input_i(local_wake), .vs_undervolt_i(vs_uv), .vcc_undervolt_i(vcc_uv),
      .bus_tx_dominant_o(bus_tx_dom), .transceiver_en_o(xcvr_en), .termination_en_o(term_en),
      .receiver_en_o(rcv_en), .regulator_en_o(reg_en), .internal_reset_n_o(int_rst_n), .mode_o(mode));

   lsm_host_model HOST (.sys_clk_i(sys_clk), .cmd_i(host_cmd), .tx_data_i(tx_data), .dev_txd_i(txd_o),
      .dev_txd_oe_n_i(txd_oe_n), .en_o(en), .txd_pin_o(txd_pin));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic pos(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic neg(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask

   // Holds the request until waitrequest is sampled low at a rising edge
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 50) begin
         chk(32'(avs_waitrequest), 32'h0);
         complete_run();
      end
   endtask

   task automatic wait_mode(input lsm_mode_t exp);
      int n;
      for (n = 0; n < 1000 && mode !== exp; n++) @(negedge sys_clk);
      if (n == 1000) begin
         chk(32'(mode), 32'(exp));
         complete_run();
      end
   endtask

   task automatic wait_rst();
      int n;
      for (n = 0; n < 200 && int_rst_n !== 1'b1; n++) @(negedge sys_clk);
      chk(32'(int_rst_n), 32'h1);
      // A hold that never ends leaves nothing worth testing
      if (n == 200) begin
         complete_run();
      end
   endtask

   task automatic to_mode(input logic [1:0] c, input lsm_mode_t m);
      pos(1);
      host_cmd <= c;
      wait_mode(m);
   endtask

   initial begin
      sys_rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      bus_rx = 1'b1;
      bus_prewake = 1'b0;
      local_wake = 1'b1;
      vs_uv = 1'b0;
      vcc_uv = 1'b0;
      host_cmd = HC_FREE;
      tx_data = 1'b1;
      pos(3);
      sys_rst <= 1'b0;
      neg(1);
      chk(32'(mode), 32'(MODE_FAILSAFE));
      chk(32'({int_rst_n, reg_en, term_en, xcvr_en}), 32'h6);
      neg(44);
      chk(32'(int_rst_n), 32'h0);
      wait_rst();
      done("power-up");
      av(1'b0, CTRL_ADDR, 32'h0, q);
      chk(q, 32'h3);
      av(1'b1, CTRL_ADDR, 32'h0, q);
      av(1'b0, CTRL_ADDR, 32'h0, q);
      chk(q, 32'h0);
      av(1'b1, CTRL_ADDR, 32'h3, q);
      av(1'b1, STATUS_ADDR, 32'hFFFFFFFF, q);
      av(1'b0, 4'h8, 32'h0, q);
      chk(q, 32'h0);
      done("registers");
      to_mode(HC_RUN, MODE_NORMAL);
      chk(32'(xcvr_en), 32'h1);
      pos(1);
      tx_data <= 1'b0;
      bus_rx <= 1'b0;
      neg(10);
      chk(32'({bus_tx_dom, rxd}), 32'h2);
      pos(1);
      bus_rx <= 1'b1;
      neg(40);
      chk(32'(bus_tx_dom), 32'h0);
      av(1'b0, STATUS_ADDR, 32'h0, q);
      chk(q, 32'h181);
      to_mode(HC_SLEEP, MODE_SLEEP);
      neg(2);
      chk(32'({reg_en, rxd, int_rst_n, term_en, xcvr_en}), 32'h0);
      done("normal-sleep");
      pos(1);
      bus_prewake <= 1'b1;
      bus_rx <= 1'b0;
      neg(10);
      chk(32'(rcv_en), 32'h1);
      pos(1);
      bus_rx <= 1'b1;
      neg(10);
      chk(32'(mode), 32'(MODE_SLEEP));
      pos(1);
      bus_rx <= 1'b0;
      pos(30);
      bus_rx <= 1'b1;
      bus_prewake <= 1'b0;
      wait_mode(MODE_FAILSAFE);
      pos(1);
      host_cmd <= HC_FREE;
      neg(3);
      chk(32'({txd_pin, rxd, term_en}), 32'h1);
      done("bus-wake");
      pos(1);
      tx_data <= 1'b1;
      to_mode(HC_RUN, MODE_NORMAL);
      av(1'b0, STATUS_ADDR, 32'h0, q);
      chk(32'(q[6:4]), 32'h0);
      to_mode(HC_SILENT, MODE_SILENT);
      neg(2);
      chk(32'({reg_en, term_en, xcvr_en, txd_o | txd_oe_n, rxd}), 32'h13);
      pos(1);
      local_wake <= 1'b0;
      wait_mode(MODE_FAILSAFE);
      pos(1);
      host_cmd <= HC_FREE;
      local_wake <= 1'b1;
      neg(3);
      chk(32'({txd_pin, rxd}), 32'h1);
      done("local-wake");
      to_mode(HC_RUN, MODE_NORMAL);
      to_mode(HC_SILENT, MODE_SILENT);
      pos(1);
      vcc_uv <= 1'b1;
      wait_mode(MODE_FAILSAFE);
      chk(32'(int_rst_n), 32'h0);
      pos(1);
      vcc_uv <= 1'b0;
      to_mode(HC_RUN, MODE_NORMAL);
      pos(1);
      vs_uv <= 1'b1;
      wait_mode(MODE_FAILSAFE);
      neg(2);
      chk(32'({txd_o, txd_oe_n, rxd}), 32'h4);
      to_mode(HC_SLEEP, MODE_SLEEP);
      pos(1);
      vs_uv <= 1'b0;
      done("undervoltage");
      complete_run();
   end
endmodule // lsm_mode_ctrl_tb_top

// File: verilog/lsm_mode_ctrl.sv
// Operating-mode controller of a bus system basis chip, with an Avalon-MM register slave.
// Assumes pins arrive asynchronously; analog regulator and bus driver act on the enables here.
//
// What this block does
// - Enable falling with transmit data high selects Silent mode.
// - Enable falling with transmit data low selects Sleep mode.
// - Power-up enters Fail-Safe, regulator on, internal reset held 4 ms.
// - Fail-Safe stays until enable goes high, then Normal.
// - Internal reset asserted by undervoltage forces Fail-Safe immediately.
// - Fail-Safe after Normal undervoltage still accepts enable falling to Sleep/Silent.
// - Wake event in Silent or Sleep moves to Fail-Safe.
// - Fail-Safe drives transmit data out and encodes the cause on both pins.
// - Normal enables transceiver, bus follows transmit data, receive data follows bus.
// - Silent disables transmitter and termination, regulator on, both pins high.
// - Sleep disables transmitter, termination, regulator; reset and receive data low.
// - Low-power modes enter at any bus level; prewake level starts bus wake detection, local wake needs none.
// - Stuck-low transmit data still allows Sleep after dominant time-out.
// - Bus and local wake both need 100 us of low level.
// - Bus wake needs falling edge, long dominant, then rising edge.
// - In Silent, bus wake is accepted only with transmit data high.
// - Local wake input falling and held low long enough requests wake.
// - Wake-source flags clear once enable high in Normal mode.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module lsm_mode_ctrl
   import lsm_pkg::*;
#(
   parameter int RESET_HOLD  = RESET_HOLD_CYC,
   parameter int WAKE_TIME   = WAKE_CYC,
   parameter int DOM_TIMEOUT = DOM_TIMEOUT_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        en_i,
   input  wire logic        txd_i,
   output logic             txd_o,
   output logic             txd_oe_n_o,
   output logic             rxd_o,
   input  wire logic        bus_rx_i,
   input  wire logic        bus_prewake_i,
   input  wire logic        local_wake_input_i,
   input  wire logic        vs_undervolt_i,
   input  wire logic        vcc_undervolt_i,
   output logic             bus_tx_dominant_o,
   output logic             transceiver_en_o,
   output logic             termination_en_o,
   output logic             receiver_en_o,
   output logic             regulator_en_o,
   output logic             internal_reset_n_o,
   output lsm_mode_t        mode_o
);

   localparam int NPIN = $bits(lsm_pins_t);

   // Three-stage synchronisers; a change is taken once stages two and three agree
   lsm_pins_t        raw;
   logic [NPIN-1:0]  sy1, sy2, sy3, filt;
   lsm_pins_t        pin;

   assign raw = '{en: en_i, txd: txd_i, bus_rx: bus_rx_i, bus_prewake: bus_prewake_i,
                  local_wake: local_wake_input_i, vs_uv: vs_undervolt_i, vcc_uv: vcc_undervolt_i};
   assign pin = lsm_pins_t'(filt);

   for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
         if (sys_rst_i) begin
            sy1[i]  <= PINS_RESET[i];
            sy2[i]  <= PINS_RESET[i];
            sy3[i]  <= PINS_RESET[i];
            filt[i] <= PINS_RESET[i];
         end else begin
            sy1[i] <= raw[i];
            sy2[i] <= sy1[i];
            sy3[i] <= sy2[i];
            if (sy2[i] == sy3[i]) begin
               filt[i] <= sy3[i];
            end
         end
      end
   end

   // State
   lsm_mode_t        mode, next_mode;
   logic             en_q;
   logic [CNT_W-1:0] rst_cnt;
   logic             sel_active;
   logic [CNT_W-1:0] sel_cnt;
   lsm_flags_t       flags, flag_set;
   logic             uv_from_normal;
   logic             rx_armed;
   logic [CNT_W-1:0] dom_cnt;
   logic             dom_timeout;
   logic [1:0]       ctrl;
   logic             ack_q;
   logic             bus_wake_raw, local_wake_raw;

   wire low_power   = (mode == MODE_SILENT) || (mode == MODE_SLEEP);
   wire vcc_fault   = pin.vcc_uv && (mode != MODE_SLEEP);
   wire reset_done  = (rst_cnt == '0);
   wire en_fall     = en_q && !pin.en;
   wire en_rise     = !en_q && pin.en;
   wire sel_allowed = reset_done && ((mode == MODE_NORMAL) || (mode == MODE_FAILSAFE && uv_from_normal));
   wire sel_done    = sel_active && (sel_cnt == '0) && !pin.en;
   wire normal_uv   = (mode == MODE_NORMAL) && pin.vs_uv;
   wire bus_wake    = bus_wake_raw && ((mode == MODE_SLEEP) || pin.txd);
   wire local_wake  = local_wake_raw;
   wire wake_any    = low_power && (bus_wake || local_wake);
   wire flag_clear  = (mode == MODE_NORMAL) && pin.en;

   // Bus wake needs falling edge, long dominant and the rising edge back
   lsm_wake_timer #(
      .CYC       (WAKE_TIME),
      .WAIT_RISE (1'b1)
   ) u_bus_wake (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .enable_i  (rx_armed && low_power && ctrl[CTRL_BUS_WAKE]),
      .level_i   (pin.bus_rx),
      .wake_o    (bus_wake_raw)
   );

   lsm_wake_timer #(
      .CYC       (WAKE_TIME),
      .WAIT_RISE (1'b0)
   ) u_local_wake (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .enable_i  (low_power && ctrl[CTRL_LOC_WAKE]),
      .level_i   (pin.local_wake),
      .wake_o    (local_wake_raw)
   );

   assign flag_set = '{vs_uv: normal_uv, local_wake: wake_any && local_wake,
                       bus_wake: wake_any && bus_wake && !local_wake};

   // Mode transitions; a supply fault overrides everything
   always_comb begin
      next_mode = mode;
      case (mode)
         MODE_FAILSAFE: begin
            if (sel_done) begin
               next_mode = pin.txd ? MODE_SILENT : MODE_SLEEP;
            end else if (reset_done && pin.en && !pin.vs_uv && !sel_active) begin
               next_mode = MODE_NORMAL;
            end
         end
         MODE_NORMAL: begin
            if (pin.vs_uv) begin
               next_mode = MODE_FAILSAFE;
            end else if (sel_done) begin
               // Stuck-low transmit data does not block a Sleep request
               next_mode = pin.txd ? MODE_SILENT : MODE_SLEEP;
            end
         end
         MODE_SILENT: begin
            if (wake_any) begin
               next_mode = MODE_FAILSAFE;
            end else if (en_rise) begin
               next_mode = MODE_NORMAL;
            end
         end
         MODE_SLEEP: begin
            if (wake_any) begin
               next_mode = MODE_FAILSAFE;
            end
         end
         default: next_mode = MODE_FAILSAFE;
      endcase
      if (vcc_fault) begin
         next_mode = MODE_FAILSAFE;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mode           <= MODE_FAILSAFE;
         en_q           <= 1'b0;
         rst_cnt        <= CNT_W'(RESET_HOLD);
         sel_active     <= 1'b0;
         sel_cnt        <= '0;
         flags          <= '0;
         uv_from_normal <= 1'b0;
         rx_armed       <= 1'b0;
      end else begin
         mode  <= next_mode;
         en_q  <= pin.en;
         flags <= (flags & ~{3{flag_clear}}) | flag_set;
         // Regulator restart after Sleep or a supply dip reloads the hold
         if (mode == MODE_SLEEP || vcc_fault) begin
            rst_cnt <= CNT_W'(RESET_HOLD);
         end else if (!reset_done) begin
            rst_cnt <= rst_cnt - CNT_W'(1);
         end
         // Window lets enable lead transmit data before the level is sampled
         if (en_fall && sel_allowed && !sel_active) begin
            sel_active <= 1'b1;
            sel_cnt    <= CNT_W'(MODE_SEL_CYC - 1);
         end else if (pin.en || next_mode != mode || vcc_fault) begin
            sel_active <= 1'b0;
         end else if (sel_cnt != '0) begin
            sel_cnt <= sel_cnt - CNT_W'(1);
         end
         if (normal_uv) begin
            uv_from_normal <= 1'b1;
         end else if (next_mode != MODE_FAILSAFE) begin
            uv_from_normal <= 1'b0;
         end
         if (!low_power) begin
            rx_armed <= 1'b0;
         end else if (pin.bus_prewake) begin
            rx_armed <= 1'b1;
         end
      end
   end

   // Transmit-data dominant time-out releases the bus until transmit data returns high
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || mode != MODE_NORMAL || pin.txd) begin
         dom_cnt     <= '0;
         dom_timeout <= 1'b0;
      end else if (dom_cnt == CNT_W'(DOM_TIMEOUT - 1)) begin
         dom_timeout <= 1'b1;
      end else begin
         dom_cnt <= dom_cnt + CNT_W'(1);
      end
   end

   // Pin outputs, registered from the current mode
   wire fs_txd = !(flags.bus_wake || flags.local_wake);
   wire fs_rxd = !(flags.bus_wake || (flags.vs_uv && !flags.local_wake));
   // During the select window in Fail-Safe the pin is released so the host can drive it
   wire drive_txd = ((mode == MODE_FAILSAFE) && !sel_active) || (mode == MODE_SLEEP);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         txd_o              <= 1'b1;
         txd_oe_n_o         <= 1'b0;
         rxd_o              <= 1'b1;
         bus_tx_dominant_o  <= 1'b0;
         transceiver_en_o   <= 1'b0;
         termination_en_o   <= 1'b1;
         receiver_en_o      <= 1'b0;
         regulator_en_o     <= 1'b1;
         internal_reset_n_o <= 1'b0;
         mode_o             <= MODE_FAILSAFE;
      end else begin
         txd_oe_n_o         <= !drive_txd;
         txd_o              <= (mode == MODE_FAILSAFE) ? fs_txd : (mode != MODE_SLEEP);
         rxd_o              <= (mode == MODE_FAILSAFE) ? fs_rxd :
                               (mode == MODE_NORMAL) ? pin.bus_rx : (mode == MODE_SILENT);
         bus_tx_dominant_o  <= (mode == MODE_NORMAL) && !pin.txd && !dom_timeout;
         transceiver_en_o   <= (mode == MODE_NORMAL);
         termination_en_o   <= !low_power;
         receiver_en_o      <= (mode == MODE_NORMAL) || rx_armed;
         regulator_en_o     <= (mode != MODE_SLEEP);
         internal_reset_n_o <= reset_done && (mode != MODE_SLEEP) && !vcc_fault;
         mode_o             <= mode;
      end
   end

   // Avalon-MM slave: one wait cycle, then the answer
   wire        req      = avs_read_i || avs_write_i;
   wire        hit_ctrl = (avs_address_i == CTRL_ADDR);
   wire        hit_stat = (avs_address_i == STATUS_ADDR);
   wire [31:0] stat_word = {23'h0, dom_timeout, internal_reset_n_o, flags, 2'h0, mode};
   wire [31:0] rd_mux    = hit_ctrl ? {30'h0, ctrl} : (hit_stat ? stat_word : 32'h0);

   assign avs_waitrequest_o = req && !ack_q;

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ack_q          <= 1'b0;
         avs_readdata_o <= 32'h0;
         ctrl           <= CTRL_RESET;
      end else begin
         ack_q <= req && !ack_q;
         if (avs_read_i && !ack_q) begin
            avs_readdata_o <= rd_mux;
         end
         if (avs_write_i && ack_q && hit_ctrl) begin
            ctrl <= avs_writedata_i[1:0];
         end
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_sel_end_high;
      sel_done && pin.txd && mode == MODE_NORMAL && !vcc_fault && !pin.vs_uv;
   endsequence
   sequence s_sel_end_low;
      sel_done && !pin.txd && mode == MODE_NORMAL && !vcc_fault && !pin.vs_uv;
   endsequence

   silent_entry_a: assert property (s_sel_end_high |=> mode == MODE_SILENT ##1 !rxd_o == 1'b0)
      else $error("Silent mode not entered after select window");
   sleep_entry_a: assert property (s_sel_end_low |=> mode == MODE_SLEEP ##1 !regulator_en_o)
      else $error("Sleep mode not entered after select window");
   reset_hold_a: assert property (!reset_done |=> !internal_reset_n_o)
      else $error("Internal reset released before hold time");
   failsafe_exit_a: assert property (mode == MODE_FAILSAFE && reset_done && pin.en && !pin.vs_uv && !sel_active
                                     && !vcc_fault |=> mode == MODE_NORMAL)
      else $error("Fail-Safe did not leave for Normal");
   supply_fault_a: assert property (vcc_fault |=> mode == MODE_FAILSAFE ##1 !internal_reset_n_o)
      else $error("Supply fault did not force Fail-Safe");
   wake_failsafe_a: assert property (wake_any && !vcc_fault |=> mode == MODE_FAILSAFE)
      else $error("Wake event did not enter Fail-Safe");
   fs_code_a: assert property (mode == MODE_FAILSAFE && !sel_active && flags.bus_wake
                               |=> !txd_o && !rxd_o && !txd_oe_n_o)
      else $error("Fail-Safe bus wake code wrong");
   normal_tx_a: assert property (mode == MODE_NORMAL && !pin.txd && !dom_timeout
                                 |=> bus_tx_dominant_o && transceiver_en_o)
      else $error("Bus not driven dominant in Normal");
   sleep_pins_a: assert property (mode == MODE_SLEEP |=> !regulator_en_o && !rxd_o && !internal_reset_n_o)
      else $error("Sleep pin levels wrong");
   flag_clear_a: assert property (flag_clear && flag_set == '0 |=> flags == '0)
      else $error("Wake flags not cleared in Normal");

endmodule // lsm_mode_ctrl

// File: verilog/lsm_wake_timer.sv
// Low-level duration detector for one wake source.
// Assumes level_i is already synchronised to sys_clk_i; high means idle.
`timescale 1ns/1ps
module lsm_wake_timer
   import lsm_pkg::*;
#(
   parameter int CYC       = WAKE_CYC,
   parameter bit WAIT_RISE = 1'b1
) (
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic enable_i,
   input  wire logic level_i,
   output logic      wake_o
);

   logic             prev;
   logic             armed;
   logic [CNT_W-1:0] cnt;

   wire fall      = prev & ~level_i;
   wire long_low  = (cnt == CNT_W'(CYC));
   wire hit_low   = armed & ~level_i & (cnt == CNT_W'(CYC - 1));
   wire hit_rise  = armed & level_i & long_low;
   wire next_wake = enable_i & (WAIT_RISE ? hit_rise : hit_low);

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !enable_i) begin
         prev  <= 1'b1;
         armed <= 1'b0;
         cnt   <= '0;
         wake_o <= 1'b0;
      end else begin
         prev   <= level_i;
         wake_o <= next_wake;
         if (fall) begin
            armed <= 1'b1;
            cnt   <= '0;
         end else if (armed && level_i) begin
            armed <= 1'b0;
         end else if (armed && !long_low) begin
            cnt <= cnt + CNT_W'(1);
         end
      end
   end

endmodule // lsm_wake_timer
